// ### sadc_top.sv
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_top #(
  parameter int NUM_CHANNELS = 12,
  parameter int CONV_SHORT_CYC = `SADC_CONV_SHORT_CYC,
  parameter int CONV_LONG_CYC = `SADC_CONV_LONG_CYC
) (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  // Data-space word access.
  input wire logic [9:0] ADDR_IN,
  input wire logic WR_EN_IN,
  input wire logic [3:0] WR_DATA_IN,
  input wire logic RD_EN_IN,
  output logic [3:0] RD_DATA_OUT,
  // Flag-area single-bit operations at the same address.
  input wire logic BIT_SET_IN,
  input wire logic BIT_CLR_IN,
  input wire logic [1:0] BIT_SEL_IN,
  // Analog side: comparator in, trial code and channel out.
  input wire logic COMP_IN,
  output logic [7:0] DAC_CODE_OUT,
  output logic [3:0] CHANNEL_SEL_OUT,
  output logic SAMPLE_OUT,
  output logic ANALOG_CURRENT_OFF_OUT,
  // Shared pin functions, one bit per channel, high means analog input.
  output logic [11:0] PIN_ANALOG_OUT,
  // Conversion-end interrupt request.
  output logic IRQ_OUT
);

  localparam int CNT_W = 7;

  sadc_pkg::sadc_ctrl_t ctrl_q;
  sadc_pkg::sadc_ctrl_t ctrl_d;
  sadc_pkg::sadc_bitop_t bitop;
  sadc_pkg::sadc_state_t state_q;
  sadc_pkg::sadc_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last_q;
  logic [CNT_W-1:0] last_d;
  logic [7:0] sar_q;
  logic [7:0] sar_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [3:0] chan_q;
  logic [3:0] chan_d;
  logic [3:0] rd_q;
  logic [3:0] rd_d;
  logic [11:0] pins_q;
  logic [11:0] pins_d;
  logic irq_q;
  logic irq_d;
  logic sample_q;
  logic sample_d;
  logic [2:0] trial_bit;
  logic done;

  // True when a single-bit operation hits the flag bit of the given word.
  function automatic logic flag_hit(input logic [9:0] addr, input logic [9:0] flag_addr,
                                    input logic [1:0] sel);
    flag_hit = (addr == flag_addr) && (sel == `SADC_FLAG_BIT);
  endfunction

  // Ones-mask for channels that exist in this configuration.
  function automatic logic [11:0] chan_mask(input int n);
    logic [11:0] m;
    m = 12'h000;
    for (int i = 0; i < 12; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    chan_mask = m;
  endfunction

  assign bitop = '{set: BIT_SET_IN, clr: BIT_CLR_IN, bit_sel: BIT_SEL_IN};
  // Bit under trial counts down from 7 as the counter reaches the last cycles.
  assign trial_bit = 3'(last_q - cnt_q);
  assign done = (state_q == sadc_pkg::SADC_TRIAL) && (cnt_q == last_q);

  // Software register writes and flag operations.
  always_comb begin
    ctrl_d = ctrl_q;
    if (WR_EN_IN) begin
      if (ADDR_IN == `SADC_ADDR_CHANNEL_SELECT) begin
        ctrl_d.input_channel_select = WR_DATA_IN;
      end else if (ADDR_IN == `SADC_ADDR_PIN_MODE_A) begin
        ctrl_d.pin_function_mode_a = WR_DATA_IN;
      end else if (ADDR_IN == `SADC_ADDR_CONV_MODE_B) begin
        ctrl_d.conversion_mode_b = WR_DATA_IN;
      end
    end
    if (done) begin
      ctrl_d.conversion_start_flag = 1'b0;
    end
    if (bitop.set && flag_hit(ADDR_IN, `SADC_ADDR_START_FLAG, bitop.bit_sel)) begin
      ctrl_d.conversion_start_flag = 1'b1;
    end
    if (flag_hit(ADDR_IN, `SADC_ADDR_CURRENT_OFF, bitop.bit_sel)) begin
      if (bitop.set) begin
        ctrl_d.analog_current_off_flag = 1'b1;
      end else if (bitop.clr) begin
        ctrl_d.analog_current_off_flag = 1'b0;
      end
    end
  end

  // Conversion sequencer: sampling phase, then eight comparator trials.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    last_d = last_q;
    sar_d = sar_q;
    result_d = result_q;
    chan_d = chan_q;
    irq_d = 1'b0;
    case (state_q)
      sadc_pkg::SADC_IDLE: begin
        if (ctrl_q.conversion_start_flag) begin
          state_d = sadc_pkg::SADC_SAMPLE;
          cnt_d = '0;
          chan_d = ctrl_q.input_channel_select;
          if (ctrl_q.conversion_mode_b[`SADC_LENGTH_SEL_BIT]) begin
            last_d = CNT_W'(CONV_LONG_CYC - 1);
          end else begin
            last_d = CNT_W'(CONV_SHORT_CYC - 1);
          end
        end
      end
      sadc_pkg::SADC_SAMPLE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == last_q - CNT_W'(`SADC_TRIAL_CYC)) begin
          state_d = sadc_pkg::SADC_TRIAL;
          sar_d = 8'h80;
        end
      end
      sadc_pkg::SADC_TRIAL: begin
        cnt_d = cnt_q + 1'b1;
        if (!COMP_IN) begin
          sar_d[trial_bit] = 1'b0;
        end
        if (trial_bit != 3'h0) begin
          sar_d[trial_bit - 3'h1] = 1'b1;
        end
        if (done) begin
          result_d = sar_d;
          irq_d = 1'b1;
          state_d = sadc_pkg::SADC_IDLE;
        end
      end
      default: begin
        state_d = sadc_pkg::SADC_IDLE;
      end
    endcase
    // Sampling indicator is registered from the next state so the pin needs no decode.
    sample_d = (state_d == sadc_pkg::SADC_SAMPLE);
  end

  // Pin functions and registered read port.
  always_comb begin
    pins_d[3:0] = ctrl_q.pin_function_mode_a;
    pins_d[7:4] = {4{ctrl_q.conversion_mode_b[`SADC_PORT_FOUR_BIT]}};
    pins_d[11:8] = {4{ctrl_q.conversion_mode_b[`SADC_PORT_FIVE_BIT]}};
    pins_d = pins_d & chan_mask(NUM_CHANNELS);
    rd_d = 4'h0;
    if (RD_EN_IN) begin
      if (ADDR_IN == `SADC_ADDR_RESULT_LOW) begin
        rd_d = result_q[3:0];
      end else if (ADDR_IN == `SADC_ADDR_RESULT_HIGH) begin
        rd_d = result_q[7:4];
      end else if (ADDR_IN == `SADC_ADDR_START_FLAG) begin
        rd_d[`SADC_FLAG_BIT] = ctrl_q.conversion_start_flag;
      end else if (ADDR_IN == `SADC_ADDR_CURRENT_OFF) begin
        rd_d[`SADC_FLAG_BIT] = ctrl_q.analog_current_off_flag;
      end
    end
  end

  // State registers with synchronous reset.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      ctrl_q <= '0;
      result_q <= `SADC_RESET_RESULT;
      state_q <= sadc_pkg::SADC_IDLE;
      cnt_q <= '0;
      last_q <= '0;
      sar_q <= 8'h00;
      chan_q <= `SADC_RESET_NIBBLE;
      rd_q <= 4'h0;
      pins_q <= 12'h000;
      irq_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      result_q <= result_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      sar_q <= sar_d;
      chan_q <= chan_d;
      rd_q <= rd_d;
      pins_q <= pins_d;
      irq_q <= irq_d;
      sample_q <= sample_d;
    end
  end

  // Outputs straight from flip-flops.
  assign RD_DATA_OUT = rd_q;
  assign DAC_CODE_OUT = sar_q;
  assign CHANNEL_SEL_OUT = chan_q;
  assign SAMPLE_OUT = sample_q;
  assign ANALOG_CURRENT_OFF_OUT = ctrl_q.analog_current_off_flag;
  assign PIN_ANALOG_OUT = pins_q;
  assign IRQ_OUT = irq_q;

endmodule // sadc_top

// ### sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// Register map, as word addresses in the data space.
`define SADC_ADDR_CHANNEL_SELECT 10'h016
`define SADC_ADDR_RESULT_LOW 10'h017
`define SADC_ADDR_RESULT_HIGH 10'h018
`define SADC_ADDR_PIN_MODE_A 10'h019
`define SADC_ADDR_CONV_MODE_B 10'h01A
`define SADC_ADDR_START_FLAG 10'h020
`define SADC_ADDR_CURRENT_OFF 10'h021

// Bit position of both flags inside their flag-area word.
`define SADC_FLAG_BIT 2'h2

// Fields of the second mode register.
`define SADC_LENGTH_SEL_BIT 0
`define SADC_PORT_FOUR_BIT 1
`define SADC_PORT_FIVE_BIT 2

// Reset values.
`define SADC_RESET_NIBBLE 4'h0
`define SADC_RESET_RESULT 8'h80

// Conversion lengths in system clock periods.
`define SADC_CONV_SHORT_CYC 34
`define SADC_CONV_LONG_CYC 67

// Number of successive-approximation trials, one per result bit.
`define SADC_TRIAL_CYC 8

`endif

// ### sadc_pkg.sv
package sadc_pkg;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_TRIAL
  } sadc_state_t;

  // Software-written control registers.
  typedef struct packed {
    logic [3:0] input_channel_select;
    logic [3:0] pin_function_mode_a;
    logic [3:0] conversion_mode_b;
    logic conversion_start_flag;
    logic analog_current_off_flag;
  } sadc_ctrl_t;

  // Single-bit operation on the flag area.
  typedef struct packed {
    logic set;
    logic clr;
    logic [1:0] bit_sel;
  } sadc_bitop_t;

endpackage

// ### sadc_assertions.sv
`timescale 1ns/10ps
// Watches the converter control block from its ports alone.
module sadc_assertions (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  // Register port.
  input wire logic [9:0] ADDR_IN,
  input wire logic WR_EN_IN,
  input wire logic [3:0] WR_DATA_IN,
  input wire logic RD_EN_IN,
  input wire logic [3:0] RD_DATA_OUT,
  // Converter side.
  input wire logic [7:0] DAC_CODE_OUT,
  input wire logic [3:0] CHANNEL_SEL_OUT,
  input wire logic SAMPLE_OUT,
  input wire logic [11:0] PIN_ANALOG_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Eight trial cycles, then a single request pulse.
  sequence s_trials;
    !IRQ_OUT [*8] ##1 IRQ_OUT ##1 !IRQ_OUT;
  endsequence
  // The first trial is mid-scale and the next tries bit 6.
  sequence s_msb_first;
    DAC_CODE_OUT == 8'h80 ##1 DAC_CODE_OUT[6] && DAC_CODE_OUT[5:0] == 6'h00;
  endsequence
  property p_trial_len; $fell(SAMPLE_OUT) |-> s_trials; endproperty
  a_trial_len: assert property (p_trial_len) else $error("trial phase length wrong");
  property p_sample_len; $rose(SAMPLE_OUT) |-> SAMPLE_OUT [*8]; endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling cut short");
  property p_first_trial; $fell(SAMPLE_OUT) |-> s_msb_first; endproperty
  a_first_trial: assert property (p_first_trial) else $error("trial order wrong");
  property p_irq_cause; IRQ_OUT |-> $past(SAMPLE_OUT, 9) && !$past(SAMPLE_OUT, 8); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without conversion");
  property p_rd_idle;
    !RD_EN_IN || ADDR_IN == 10'h019 || ADDR_IN == 10'h016 |=> RD_DATA_OUT == 4'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  // Pin functions follow the mode register two cycles after it is written.
  property p_pin_a;
    WR_EN_IN && ADDR_IN == 10'h019 ##1 !(WR_EN_IN && ADDR_IN == 10'h019)
      |=> PIN_ANALOG_OUT[3:0] == $past(WR_DATA_IN, 2);
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("port three pins wrong");
  property p_pin_four;
    WR_EN_IN && ADDR_IN == 10'h01A && WR_DATA_IN[1] ##1 !(WR_EN_IN && ADDR_IN == 10'h01A)
      |=> &PIN_ANALOG_OUT[7:4];
  endproperty
  a_pin_four: assert property (p_pin_four) else $error("port four pins wrong");
  property p_pin_five;
    WR_EN_IN && ADDR_IN == 10'h01A && WR_DATA_IN[2] ##1 !(WR_EN_IN && ADDR_IN == 10'h01A)
      |=> &PIN_ANALOG_OUT[11:8];
  endproperty
  a_pin_five: assert property (p_pin_five) else $error("port five pins wrong");
  property p_chan_hold; SAMPLE_OUT && $past(SAMPLE_OUT) |-> $stable(CHANNEL_SEL_OUT); endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved in sampling");
  // Counts sampling cycles and keeps the length select that was in force at the start.
  logic [6:0] smp_cnt_q;
  logic long_q;
  logic len_q;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      smp_cnt_q <= 7'h00;
      long_q <= 1'b0;
      len_q <= 1'b0;
    end else begin
      if (WR_EN_IN && ADDR_IN == 10'h01A) begin
        long_q <= WR_DATA_IN[0];
      end
      if (!SAMPLE_OUT) begin
        len_q <= long_q;
      end
      if (SAMPLE_OUT) begin
        smp_cnt_q <= smp_cnt_q + 7'h01;
      end else begin
        smp_cnt_q <= 7'h00;
      end
    end
  end
  // Sampling plus the eight trials must make up the whole conversion time.
  property p_conv_len; $fell(SAMPLE_OUT) |-> smp_cnt_q == (len_q ? 7'h3B : 7'h1A); endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
endmodule // sadc_assertions

bind sadc_top sadc_assertions sadc_assertions_i (.SYS_CLK_IN, .RESET_N_IN, .ADDR_IN, .WR_EN_IN,
  .WR_DATA_IN, .RD_EN_IN, .RD_DATA_OUT, .DAC_CODE_OUT, .CHANNEL_SEL_OUT, .SAMPLE_OUT,
  .PIN_ANALOG_OUT, .IRQ_OUT);

// ### sadc_comparator_model.sv
`timescale 1ns/10ps
// Ideal comparator on the selected analog input.
module sadc_comparator_model (
  // Trial code and input level.
  input wire logic [7:0] dac_code_in,
  input wire logic [7:0] level_in,
  // Decision.
  output logic comp_out
);
  // one step per code
  // High while the input sits at or above the trial code.
  assign comp_out = level_in >= dac_code_in;
endmodule // sadc_comparator_model

// ### sadc_top_tb.sv
`timescale 1ns/10ps
module sadc_top_tb;
  localparam logic [3:0] WR = 4'h8, RD = 4'h4, SET = 4'h2, CLR = 4'h1;
  logic clk = 1'b0;
  logic rst_n, wr_en, rd_en, bset, bclr, comp, smp, coff, irq;
  logic [9:0] addr;
  logic [3:0] wdata, rdata, chan;
  logic [1:0] bsel;
  logic [7:0] dac, level;
  logic [11:0] pins;
  int bad_count = 0, checks = 0, cyc = 0, t0 = 0;

  sadc_top sadc_top_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WR_EN_IN(wr_en),
    .WR_DATA_IN(wdata), .RD_EN_IN(rd_en), .RD_DATA_OUT(rdata), .BIT_SET_IN(bset),
    .BIT_CLR_IN(bclr), .BIT_SEL_IN(bsel), .COMP_IN(comp), .DAC_CODE_OUT(dac),
    .CHANNEL_SEL_OUT(chan), .SAMPLE_OUT(smp), .ANALOG_CURRENT_OFF_OUT(coff),
    .PIN_ANALOG_OUT(pins), .IRQ_OUT(irq));
  sadc_comparator_model sadc_comparator_model_i (.dac_code_in(dac), .level_in(level),
    .comp_out(comp));

  // Clock and a free cycle count for timing conversions.
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Compares a seen value with the expected one.
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One register port access, then an idle cycle so strobes never toggle twice at once.
  task automatic op(input logic [3:0] kind, input logic [9:0] a, input logic [3:0] d,
                    input logic [3:0] exp);
    addr = a;
    wdata = d;
    bsel = 2'h2;
    {wr_en, rd_en, bset, bclr} = kind;
    @(negedge clk) {wr_en, rd_en, bset, bclr} = 4'h0;
    t0 = cyc;
    if (kind[2]) chk({8'h00, rdata}, {8'h00, exp});
    @(negedge clk);
  endtask

  // Runs one conversion and checks its timing, channel and result.
  task automatic conv(input logic len, input logic [3:0] ch, input logic [7:0] lvl);
    int n;
    level = lvl;
    op(WR, 10'h016, ch, 4'h0);
    op(WR, 10'h01A, {3'h3, len}, 4'h0);
    op(SET, 10'h020, 4'h0, 4'h0);
    n = t0;
    op(CLR, 10'h020, 4'h0, 4'h0);
    op(RD, 10'h020, 4'h0, 4'h4);
    while (irq !== 1'b1 && cyc - n < 100) @(negedge clk);
    chk(12'(cyc - n), len ? 12'h044 : 12'h023);
    chk({8'h00, chan}, {8'h00, ch});
    op(RD, 10'h020, 4'h0, 4'h0);
    op(RD, 10'h018, 4'h0, lvl[7:4]);
    op(RD, 10'h017, 4'h0, lvl[3:0]);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence: reset, pin functions, flags, then conversions at both lengths.
  initial begin
    {rst_n, wr_en, rd_en, bset, bclr} = 5'h00;
    addr = 10'h000;
    wdata = 4'h0;
    bsel = 2'h0;
    level = 8'h00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    op(RD, 10'h017, 4'h0, 4'h0);
    op(RD, 10'h018, 4'h0, 4'h8);
    op(RD, 10'h01A, 4'h0, 4'h0);
    chk(pins, 12'h000);
    op(WR, 10'h019, 4'hA, 4'h0);
    op(WR, 10'h01A, 4'h6, 4'h0);
    chk(pins, 12'hFFA);
    op(SET, 10'h021, 4'h0, 4'h0);
    chk({11'h000, coff}, 12'h001);
    op(CLR, 10'h021, 4'h0, 4'h0);
    chk({11'h000, coff}, 12'h000);
    conv(1'b0, 4'hB, 8'hFF);
    conv(1'b1, 4'h5, 8'h00);
    conv(1'b0, 4'h0, 8'h5A);
    end_of_test;
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule // sadc_top_tb
